// [logic/hoc_map.svh]
`ifndef HOC_MAP_SVH
`define HOC_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS          100
`define TICK_MS         5
`define PRE_TRIG_MS     20
`define PRE_FAULT_MS    200
`define NS_PER_MS       1000000

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define N_STAGE         4
`define REC_DEPTH       12
`define HIST_DEPTH      41
`define CNT_W           10

// ----------------------------------------------------------------
// scaling and levels
// ----------------------------------------------------------------
`define PU_SCALE        40'h64
`define REL_SCALE       40'h2710
`define HYST_DEN        40'h64
`define HYST_NUM        40'h61
`define LVL_PU_MIN      16'h0005
`define LVL_PU_MAX      16'h00C8
`define LVL_PU_RST      16'h0014
`define LVL_REL_MIN     16'h01F4
`define LVL_REL_MAX     16'h4E20
`define LVL_REL_RST     16'h07D0
`define OP_DELAY_RST    20'h00014
`define REL_DELAY_RST   20'h00000
`define EV_MASK_RST     6'h3F

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define STAGE_STRIDE_LSB 5
`define OFS_CFG         5'h00
`define OFS_LVL_PU      5'h04
`define OFS_LVL_REL     5'h08
`define OFS_OP_DELAY    5'h0C
`define OFS_REL_DELAY   5'h10
`define OFS_EV_MASK     5'h14
`define OFS_STATUS      5'h18
`define OFS_COUNT       5'h1C
`define OFS_REC_SEL     8'h80
`define OFS_REC_STAMP   8'h84
`define OFS_REC_INFO    8'h88
`define OFS_REC_CUR     8'h8C
`define OFS_REC_PRE     8'h90

// ----------------------------------------------------------------
// event bits
// ----------------------------------------------------------------
`define EV_START_ON     0
`define EV_START_OFF    1
`define EV_TRIP_ON      2
`define EV_TRIP_OFF     3
`define EV_BLK_ON       4
`define EV_BLK_OFF      5

`endif

// [logic/hoc_pkg.sv]
`default_nettype none
package hoc_pkg;

  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} cond_t;
  typedef enum logic [1:0] {SRC_PHASE, SRC_RES1, SRC_RES2} src_t;

  typedef struct packed {
    logic [2:0][15:0] ph_harm;
    logic [2:0][15:0] ph_fund;
    logic [15:0]      r1_harm;
    logic [15:0]      r1_fund;
    logic [15:0]      r2_harm;
    logic [15:0]      r2_fund;
  } meas_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  stage;
    logic [5:0]  bits;
    logic [31:0] stamp;
  } event_t;

  typedef struct packed {
    logic        rel;
    src_t        src;
    logic        idmt;
    logic [2:0]  group;
    logic [15:0] lvl_pu;
    logic [15:0] lvl_rel;
    logic [19:0] op_delay;
    logic [19:0] rel_delay;
    logic [5:0]  ev_mask;
  } stage_cfg_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0]  ev;
    logic [2:0]  ftype;
    logic [2:0]  group;
    logic [20:0] remain;
    logic [15:0] pre20;
    logic [15:0] fault;
    logic [15:0] pre200;
  } record_t;

endpackage
`default_nettype wire

// [logic/harmonic_overcurrent_stage.sv]
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "hoc_map.svh"

module harmonic_overcurrent_stage #(
  parameter int unsigned TICK_CYCLES = `TICK_MS * `NS_PER_MS / `CLK_NS,
  parameter int unsigned CNT_W       = `CNT_W
) (
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire hoc_pkg::meas_t meas_i,
  input  wire logic [3:0]     block_i,
  output logic      [3:0]     start_o,
  output logic      [3:0]     trip_o,
  output logic      [3:0]     blocked_o,
  output hoc_pkg::event_t     event_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       pick;
    logic [19:0]      elapsed;
    logic [19:0]      rel_cnt;
    logic [CNT_W-1:0] n_start;
    logic [CNT_W-1:0] n_trip;
    logic [CNT_W-1:0] n_blk;
    logic [3:0]       wp;
  } stage_st_t;

  typedef struct packed {
    logic [19:0]                        div;
    logic                               tick;
    logic                               eval;
    logic [1:0]                         idx;
    logic [31:0]                        stamp;
    logic [5:0]                         hp;
    hoc_pkg::meas_t                     snap;
    logic [3:0]                         blk;
    hoc_pkg::stage_cfg_t [`N_STAGE-1:0] cfg;
    stage_st_t [`N_STAGE-1:0]           stg;
    logic [3:0]                         start;
    logic [3:0]                         trip;
    logic [3:0]                         blocked;
    logic [1:0]                         rsel_stage;
    logic [3:0]                         rsel_idx;
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
    hoc_pkg::event_t                    evt;
  } state_t;

  localparam hoc_pkg::stage_cfg_t CFG_RST = '{
    rel: 1'b0, src: hoc_pkg::SRC_PHASE, idmt: 1'b0, group: 3'h0,
    lvl_pu: `LVL_PU_RST, lvl_rel: `LVL_REL_RST, op_delay: `OP_DELAY_RST,
    rel_delay: `REL_DELAY_RST, ev_mask: `EV_MASK_RST};
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  state_t st_q;
  state_t st_d;

  // too many words for flops in the struct, so these live as arrays
  hoc_pkg::record_t rec_mem  [`N_STAGE][`REC_DEPTH];
  logic [15:0]      hist_mem [`N_STAGE][`HIST_DEPTH];

  logic             rec_we;
  hoc_pkg::record_t rec_wdata;
  logic             hist_we;
  logic [15:0]      hist_wdata;
  logic [1:0]       ev_s;
  logic             above_any;
  logic             pick_any;
  logic             blk_now;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [5:0] ring_back(input logic [5:0] p, input logic [5:0] k,
                                           input logic [5:0] depth);
    ring_back = (p >= k) ? 6'(p - k) : 6'(p + depth - k);
  endfunction

  function automatic logic [1:0] cond_of(input logic s, input logic t, input logic b);
    hoc_pkg::cond_t c;
    c = t ? hoc_pkg::COND_TRIP : (s ? hoc_pkg::COND_START :
        (b ? hoc_pkg::COND_BLOCKED : hoc_pkg::COND_NORMAL));
    cond_of = c;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    hoc_pkg::stage_cfg_t c;
    stage_st_t           g;
    logic [2:0]          valid;
    logic [15:0]         h;
    logic [15:0]         f;
    logic [15:0]         lvl;
    logic [39:0]         v;
    logic [39:0]         t;
    logic [39:0]         vmax;
    logic [39:0]         tmax;
    logic [15:0]         hmax;
    logic [2:0]          above;
    logic [19:0]         inc;
    logic                s_n;
    logic                t_n;
    logic                b_n;
    logic [5:0]          raw;
    logic [1:0]          ws;
    logic [4:0]          wr;
    logic [3:0]          ent;
    logic                setup;
    logic                wr_en;
    hoc_pkg::record_t    rr;
    c = '0; g = '0; valid = '0; h = '0; f = '0; lvl = '0; v = '0; t = '0;
    vmax = '0; tmax = '0; hmax = '0; above = '0; inc = '0;
    s_n = 1'b0; t_n = 1'b0; b_n = 1'b0; raw = '0;
    st_d = st_q;
    rec_we = 1'b0; rec_wdata = '0; hist_we = 1'b0; hist_wdata = '0;
    above_any = 1'b0; pick_any = 1'b0; blk_now = 1'b0;
    ev_s = st_q.idx;
    st_d.evt.valid = 1'b0;
    st_d.tick = 1'b0;

    // apb: data is latched in setup so pready and prdata come from flops
    setup = psel && !penable;
    wr_en = psel && penable && pwrite && st_q.pready;
    ws = paddr[6:5];
    wr = paddr[4:0];
    ent = 4'(ring_back({2'h0, st_q.stg[st_q.rsel_stage].wp},
                       {2'h0, st_q.rsel_idx} + 6'h1, 6'(`REC_DEPTH)));
    rr = rec_mem[st_q.rsel_stage][ent];
    st_d.pready = setup;
    if (setup) begin
      st_d.prdata = '0;
      st_d.pslverr = 1'b0;
      if (!paddr[7]) begin
        unique case (wr)
          `OFS_CFG: st_d.prdata = {25'h0, st_q.cfg[ws].group, st_q.cfg[ws].idmt,
                                   st_q.cfg[ws].src, st_q.cfg[ws].rel};
          `OFS_LVL_PU: st_d.prdata = {16'h0, st_q.cfg[ws].lvl_pu};
          `OFS_LVL_REL: st_d.prdata = {16'h0, st_q.cfg[ws].lvl_rel};
          `OFS_OP_DELAY: st_d.prdata = {12'h0, st_q.cfg[ws].op_delay};
          `OFS_REL_DELAY: st_d.prdata = {12'h0, st_q.cfg[ws].rel_delay};
          `OFS_EV_MASK: st_d.prdata = {26'h0, st_q.cfg[ws].ev_mask};
          `OFS_STATUS: st_d.prdata = {21'(st_q.cfg[ws].op_delay - st_q.stg[ws].elapsed),
                                      8'h0, |st_q.stg[ws].pick,
                                      cond_of(st_q.start[ws], st_q.trip[ws],
                                              st_q.blocked[ws])};
          `OFS_COUNT: st_d.prdata = 32'({st_q.stg[ws].n_blk, st_q.stg[ws].n_trip,
                                         st_q.stg[ws].n_start});
          default: st_d.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `OFS_REC_SEL: st_d.prdata = {20'h0, st_q.rsel_idx, 6'h0, st_q.rsel_stage};
          `OFS_REC_STAMP: st_d.prdata = rr.stamp;
          `OFS_REC_INFO: st_d.prdata = {rr.remain, rr.group, rr.ftype, 2'h0, rr.ev};
          `OFS_REC_CUR: st_d.prdata = {rr.pre20, rr.fault};
          `OFS_REC_PRE: st_d.prdata = {16'h0, rr.pre200};
          default: st_d.pslverr = 1'b1;
        endcase
      end
    end
    if (wr_en && !paddr[7]) begin
      unique case (wr)
        `OFS_CFG: begin
          st_d.cfg[ws].rel = pwdata[0];
          st_d.cfg[ws].src = (pwdata[2:1] == 2'h3) ? hoc_pkg::SRC_PHASE
                                                   : hoc_pkg::src_t'(pwdata[2:1]);
          st_d.cfg[ws].idmt = pwdata[3];
          st_d.cfg[ws].group = pwdata[6:4];
        end
        `OFS_LVL_PU: st_d.cfg[ws].lvl_pu = clamp16(pwdata[15:0], `LVL_PU_MIN,
                                                   `LVL_PU_MAX);
        `OFS_LVL_REL: st_d.cfg[ws].lvl_rel = clamp16(pwdata[15:0], `LVL_REL_MIN,
                                                     `LVL_REL_MAX);
        `OFS_OP_DELAY: st_d.cfg[ws].op_delay = pwdata[19:0];
        `OFS_REL_DELAY: st_d.cfg[ws].rel_delay = pwdata[19:0];
        `OFS_EV_MASK: st_d.cfg[ws].ev_mask = pwdata[5:0];
        `OFS_COUNT: begin
          if (pwdata[0]) begin
            st_d.stg[ws].n_start = '0;
            st_d.stg[ws].n_trip = '0;
            st_d.stg[ws].n_blk = '0;
          end
        end
        default: begin
        end
      endcase
    end
    if (wr_en && paddr == `OFS_REC_SEL) begin
      st_d.rsel_stage = pwdata[1:0];
      st_d.rsel_idx = (pwdata[11:8] >= 4'(`REC_DEPTH)) ? 4'(`REC_DEPTH - 1) : pwdata[11:8];
    end

    // tick: snapshot inputs and blocking first, then one stage per cycle
    if (st_q.div == TICK_LAST) begin
      st_d.div = '0;
      st_d.tick = 1'b1;
      st_d.snap = meas_i;
      st_d.blk = block_i;
      st_d.stamp = st_q.stamp + 32'h1;
      st_d.eval = 1'b1;
      st_d.idx = '0;
    end else begin
      st_d.div = st_q.div + 20'h1;
    end

    if (st_q.eval) begin
      c = st_d.cfg[st_q.idx];
      g = st_d.stg[st_q.idx];
      blk_now = st_q.blk[st_q.idx];
      valid = (c.src == hoc_pkg::SRC_PHASE) ? 3'h7 : 3'h1;
      lvl = c.rel ? c.lvl_rel : c.lvl_pu;
      for (int k = 0; k < 3; k++) begin
        h = (c.src == hoc_pkg::SRC_PHASE) ? st_q.snap.ph_harm[k] :
            ((c.src == hoc_pkg::SRC_RES1) ? st_q.snap.r1_harm : st_q.snap.r2_harm);
        f = (c.src == hoc_pkg::SRC_PHASE) ? st_q.snap.ph_fund[k] :
            ((c.src == hoc_pkg::SRC_RES1) ? st_q.snap.r1_fund : st_q.snap.r2_fund);
        v = c.rel ? 40'(h) * `REL_SCALE : 40'(h) * `PU_SCALE;
        t = c.rel ? 40'(lvl) * 40'(f) : 40'(lvl) * `PU_SCALE;
        above[k] = valid[k] && (v > t);
        g.pick[k] = valid[k] && (above[k] ||
                    (g.pick[k] && !(v * `HYST_DEN < t * `HYST_NUM)));
        if (valid[k] && v >= vmax) begin
          vmax = v;
          tmax = t;
          hmax = h;
        end
      end
      above_any = |above;
      pick_any = |g.pick;
      // inverse curve: larger excess advances the timer faster
      inc = (!c.idmt) ? 20'h1 : ((vmax > (tmax << 2)) ? 20'h4 :
            ((vmax > (tmax << 1)) ? 20'h2 : 20'h1));
      if (pick_any && !blk_now) begin
        s_n = 1'b1;
        g.rel_cnt = '0;
        g.elapsed = g.elapsed + inc;
        t_n = (g.elapsed >= c.op_delay);
      end else begin
        b_n = pick_any && blk_now;
        if (g.elapsed != '0) begin
          g.rel_cnt = g.rel_cnt + 20'h1;
          if (g.rel_cnt >= c.rel_delay) begin
            g.elapsed = '0;
            g.rel_cnt = '0;
          end
        end
      end
      raw[`EV_START_ON] = s_n && !st_q.start[st_q.idx];
      raw[`EV_START_OFF] = !s_n && st_q.start[st_q.idx];
      raw[`EV_TRIP_ON] = t_n && !st_q.trip[st_q.idx];
      raw[`EV_TRIP_OFF] = !t_n && st_q.trip[st_q.idx];
      raw[`EV_BLK_ON] = b_n && !st_q.blocked[st_q.idx];
      raw[`EV_BLK_OFF] = !b_n && st_q.blocked[st_q.idx];
      g.n_start = g.n_start + CNT_W'(raw[`EV_START_ON]);
      g.n_trip = g.n_trip + CNT_W'(raw[`EV_TRIP_ON]);
      g.n_blk = g.n_blk + CNT_W'(raw[`EV_BLK_ON]);
      st_d.evt.valid = |(raw & c.ev_mask);
      st_d.evt.stage = st_q.idx;
      st_d.evt.bits = raw & c.ev_mask;
      st_d.evt.stamp = st_q.stamp;
      hist_we = 1'b1;
      hist_wdata = hmax;
      if (raw[`EV_START_ON] || raw[`EV_TRIP_ON] || raw[`EV_BLK_ON]) begin
        rec_we = 1'b1;
        rec_wdata.stamp = st_q.stamp;
        rec_wdata.ev = {raw[`EV_BLK_ON], raw[`EV_TRIP_ON], raw[`EV_START_ON]};
        rec_wdata.ftype = g.pick;
        rec_wdata.group = c.group;
        rec_wdata.remain = 21'(c.op_delay - g.elapsed);
        rec_wdata.fault = hmax;
        rec_wdata.pre20 = hist_mem[st_q.idx][ring_back(st_q.hp,
                          6'(`PRE_TRIG_MS / `TICK_MS), 6'(`HIST_DEPTH))];
        rec_wdata.pre200 = hist_mem[st_q.idx][ring_back(st_q.hp,
                           6'(`PRE_FAULT_MS / `TICK_MS), 6'(`HIST_DEPTH))];
        g.wp = (g.wp == 4'(`REC_DEPTH - 1)) ? 4'h0 : g.wp + 4'h1;
      end
      st_d.stg[st_q.idx] = g;
      st_d.start[st_q.idx] = s_n;
      st_d.trip[st_q.idx] = t_n;
      st_d.blocked[st_q.idx] = b_n;
      st_d.idx = st_q.idx + 2'h1;
      if (st_q.idx == 2'(`N_STAGE - 1)) begin
        st_d.eval = 1'b0;
        st_d.hp = (st_q.hp == 6'(`HIST_DEPTH - 1)) ? 6'h0 : st_q.hp + 6'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
      st_q.cfg <= {`N_STAGE{CFG_RST}};
    end else begin
      st_q <= st_d;
      if (rec_we) begin
        rec_mem[ev_s][st_q.stg[ev_s].wp] <= rec_wdata;
      end
      if (hist_we) begin
        hist_mem[ev_s][st_q.hp] <= hist_wdata;
      end
    end
  end

  assign prdata    = st_q.prdata;
  assign pready    = st_q.pready;
  assign pslverr   = st_q.pslverr;
  assign start_o   = st_q.start;
  assign trip_o    = st_q.trip;
  assign blocked_o = st_q.blocked;
  assign event_o   = st_q.evt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_eval_pick;
    st_q.eval && above_any && !blk_now;
  endsequence

  chk_pick_start: assert property (s_eval_pick |=> start_o[$past(st_q.idx)])
    else $error("pick-up without start");
  chk_hyst_hold: assert property (st_q.eval && !above_any && pick_any && !blk_now
    |=> start_o[$past(st_q.idx)])
    else $error("start dropped inside hysteresis band");
  chk_block_quiet: assert property (st_q.eval && pick_any && blk_now
    |=> blocked_o[$past(st_q.idx)] && !start_o[$past(st_q.idx)]
        && !trip_o[$past(st_q.idx)])
    else $error("blocked stage still timing");
  chk_block_drop: assert property (st_q.eval && blk_now
    |=> !start_o[$past(st_q.idx)])
    else $error("start kept while blocked");
  chk_tick_gap: assert property (st_q.tick |=> !st_q.tick [*8])
    else $error("tick too frequent");
  chk_eval_span: assert property (st_q.tick |-> st_q.eval ##4 !st_q.eval)
    else $error("stage sweep not four cycles");
  chk_trip_start: assert property ($rose(trip_o[0]) |-> start_o[0])
    else $error("trip without start");
  chk_event_stamp: assert property (event_o.valid |-> event_o.stamp == st_q.stamp)
    else $error("event stamp mismatch");
  chk_rec_wrap: assert property (st_q.stg[0].wp < 4'(`REC_DEPTH))
    else $error("record pointer out of range");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("apb answer late");

endmodule
`default_nettype wire

// [testbench/meas_front.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// measurement front end and blocking matrix
// ----------------------------------------------------------------
module meas_front (
  input  wire logic [15:0]    harm_cmd,
  input  wire logic [15:0]    fund_cmd,
  input  wire logic [3:0]     blk_cmd,
  output var  hoc_pkg::meas_t meas_o,
  output logic      [3:0]     block_o
);
  // harmonic only on the third phase, so a single-phase fault is exercised
  always_comb begin
    meas_o            = '0;
    meas_o.ph_harm[2] = harm_cmd;
    meas_o.ph_fund    = {3{fund_cmd}};
  end
  // bench raises blocking ticks ahead of operate delay expiry; on stage 3 blocking rises in the same tick as the fault
  assign block_o = blk_cmd;
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic            mclk    = 1'b0;
  logic            reset   = 1'b1;
  logic            psel    = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite  = 1'b0;
  logic [7:0]      paddr   = 8'h00;
  logic [31:0]     pwdata  = 32'h0;
  logic [15:0]     harm    = 16'h0000;
  logic [15:0]     fund    = 16'h0064;
  logic [3:0]      blk     = 4'h0;
  logic [5:0]      ev0     = 6'h00;
  logic [31:0]     prdata;
  logic [31:0]     rd_v;
  logic            pready;
  logic            pslverr;
  logic            rd_e;
  logic [3:0]      blk_w;
  logic [3:0]      start_o;
  logic [3:0]      trip_o;
  logic [3:0]      blocked_o;
  hoc_pkg::meas_t  meas;
  hoc_pkg::event_t event_o;
  int              err_count = 0;
  int              compares  = 0;
  int              cycles    = 0;

  always #50 mclk = ~mclk;

  meas_front partner (.harm_cmd(harm), .fund_cmd(fund), .blk_cmd(blk), .meas_o(meas),
                      .block_o(blk_w));

  harmonic_overcurrent_stage #(.TICK_CYCLES(16)) uut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_i(meas), .block_i(blk_w), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .event_o(event_o));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle count assumed: a hung slave is caught by the bench timeout
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd_v    = prdata;
    rd_e    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // ----------------------------------------------------------------
  // monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (event_o.valid === 1'b1 && event_o.stage === 2'd0) ev0 <= ev0 | event_o.bits;
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // waits below span whole ticks of 16 cycles plus the stage offset
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({19'h0, event_o.valid, start_o, trip_o, blocked_o}, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h14);
    rd(8'h08, 32'h7D0);
    rd(8'h14, 32'h3F);
    // remaining time field shows the full operate delay while idle
    rd(8'h18, 32'hA000);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h5);
    wr(8'h04, 32'hFFFF);
    rd(8'h04, 32'hC8);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h1F4);
    apb(1'b0, 8'hA0, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    wr(8'h04, 32'h14);
    wr(8'h08, 32'h7D0);
    wr(8'h0C, 32'h3);
    wr(8'h6C, 32'h1);
    blk  <= 4'h8;
    harm <= 16'h0015;
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o}, 32'h7);
    chk({28'h0, blocked_o}, 32'h8);
    chk({28'h0, trip_o}, 32'h0);
    repeat (40) @(posedge mclk);
    chk({28'h0, trip_o}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd_v & 32'h7, 32'h6);
    blk <= 4'hA;
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o}, 32'h5);
    harm <= 16'h0014;
    repeat (40) @(posedge mclk);
    chk({28'h0, start_o}, 32'h5);
    harm <= 16'h0013;
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o | trip_o}, 32'h0);
    chk({26'h0, ev0}, 32'hF);
    rd(8'h1C, 32'h401);
    wr(8'h1C, 32'h1);
    rd(8'h1C, 32'h0);
    rd(8'h7C, 32'h100000);
    // stage 0 holds a start record (stamp 4) and a trip record (stamp 6)
    wr(8'h80, 32'h0);
    rd(8'h84, 32'h6);
    rd(8'h88, 32'h82);
    rd(8'h8C, 32'h15);
    wr(8'h80, 32'h100);
    rd(8'h84, 32'h4);
    rd(8'h88, 32'h1081);
    // relative mode: 21 of 200 is below the 20 percent level
    wr(8'h00, 32'h1);
    fund <= 16'h00C8;
    harm <= 16'h0015;
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o}, 32'h4);
    fund <= 16'h0064;
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o}, 32'h5);
    // inverse time on stage 2: fivefold excess steps by 4, trips long before 20 ticks
    wr(8'h40, 32'h8);
    harm <= 16'h0064;
    repeat (100) @(posedge mclk);
    chk({28'h0, trip_o}, 32'h5);
    // stage 2 moved to the first residual input, which carries nothing
    wr(8'h40, 32'h2);
    repeat (22) @(posedge mclk);
    chk({28'h0, start_o | trip_o}, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
